// file: rtl/cfm_pkg.sv
package cfm_pkg;

   // ***************************************************
   // Timing
   // ***************************************************
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned WINDOW_MS     = 250;
   localparam int unsigned WINDOW_CYC    = WINDOW_MS * (CLK_HZ / 1000);

   // ***************************************************
   // Monitoring mode and sequencer states
   // ***************************************************
   typedef enum logic [1:0] {
      CFM_MODE_NONE = 2'h0,
      CFM_MODE_ONE  = 2'h1,
      CFM_MODE_TWO  = 2'h2
   } cfm_mode_e;

   typedef enum logic [3:0] {
      CFM_ST_WAIT = 4'h1,
      CFM_ST_RUN  = 4'h2,
      CFM_ST_OFF  = 4'h4,
      CFM_ST_LOCK = 4'h8
   } cfm_state_e;

endpackage : cfm_pkg

// file: rtl/cfm_timer_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cfm_timer_if;
   logic cond;
   logic expired;
   modport timer (input cond, output expired);
   modport user  (output cond, input expired);
endinterface : cfm_timer_if

`default_nettype wire

// file: rtl/cfm_top.sv
// Contract
// - One feedback input may guard one or several switched safety outputs, chosen by a map.
// - The feedback check runs either as a one-channel or as a two-channel check.
// - With checking off (the default) every output follows its request unconditionally.
// - One-channel: a reset is refused unless the series feedback contact reads closed.
// - One-channel: while outputs are on after a reset, feedback changes are ignored.
// - One-channel: feedback must read closed within 250 ms after outputs turn off.
// - Two-channel: both feedback inputs must read closed for a reset and for turn-on.
// - Two-channel: both inputs changing together while on is tolerated.
// - Two-channel: inputs opposite for longer than 250 ms cause lockout.
`timescale 1ns/1ps
`default_nettype none

module cfm_top
   import cfm_pkg::*;
#(
   parameter int unsigned N_OUT       = 4,
   parameter int unsigned WINDOW_CYCS = cfm_pkg::WINDOW_CYC
) (
   input  wire logic             clk,            // System clock
   input  wire logic             rst,            // Sync reset, active high
   input  wire cfm_pkg::cfm_mode_e mode,         // Feedback check mode
   input  wire logic [N_OUT-1:0] out_map,        // Outputs guarded by the feedback
   input  wire logic [N_OUT-1:0] out_req,        // Logical output requests
   input  wire logic             reset_req,      // Manual or automatic reset pulse
   input  wire logic             fb_a_closed,    // Feedback channel A closed
   input  wire logic             fb_b_closed,    // Feedback channel B closed
   output logic [N_OUT-1:0]      sso_q,          // Switched safety outputs
   output logic                  lockout_q,      // Lockout state
   output logic                  reset_refused_q,// Reset refused, one-cycle pulse
   output logic                  armed_q         // Guarded outputs allowed on
);
   import cfm_pkg::*;

   typedef struct packed {
      cfm_state_e       st;
      logic [N_OUT-1:0] sso;
      logic             refused;
   } cfm_top_s;

   cfm_top_s s_q;
   cfm_top_s s_d;

   cfm_timer_if off_tif ();
   cfm_timer_if dis_tif ();

   logic mon_en;
   logic two_ch;
   logic fb_ok;
   logic any_guarded_req;

   initial
   begin
      if (N_OUT < 1)
         $error("cfm_top: N_OUT must be at least 1");
      if (WINDOW_CYCS < 2)
         $error("cfm_top: WINDOW_CYCS must be at least 2");
   end

   // ***************************************************
   // Mode decode
   // ***************************************************
   always_comb
   begin
      mon_en          = (mode != CFM_MODE_NONE) && (out_map != '0);
      two_ch          = (mode == CFM_MODE_TWO);
      fb_ok           = two_ch ? (fb_a_closed && fb_b_closed)
                               : fb_a_closed;
      any_guarded_req = |(out_req & out_map);
   end

   // ***************************************************
   // Windows
   // ***************************************************
   assign off_tif.cond = mon_en && !two_ch && (s_q.st == CFM_ST_OFF)
                         && !fb_a_closed;
   assign dis_tif.cond = mon_en && two_ch
                         && (fb_a_closed != fb_b_closed);

   cfm_window_timer #(
      .LIMIT (WINDOW_CYCS)
   ) u_off_timer (
      .clk (clk),
      .rst (rst),
      .tif (off_tif)
   );

   cfm_window_timer #(
      .LIMIT (WINDOW_CYCS + 1)
   ) u_dis_timer (
      .clk (clk),
      .rst (rst),
      .tif (dis_tif)
   );

   // ***************************************************
   // Sequencer
   // ***************************************************
   always_comb
   begin
      s_d         = s_q;
      s_d.refused = 1'b0;
      unique case (s_q.st)
         CFM_ST_WAIT:
         begin
            if (reset_req)
            begin
               if (fb_ok)
                  s_d.st = CFM_ST_RUN;
               else
                  s_d.refused = mon_en;
            end
         end
         CFM_ST_RUN:
         begin
            // Feedback not looked at here in one-channel mode
            if (!any_guarded_req)
               s_d.st = two_ch ? CFM_ST_WAIT : CFM_ST_OFF;
         end
         CFM_ST_OFF:
         begin
            if (off_tif.expired)
               s_d.st = CFM_ST_LOCK;
            else if (fb_a_closed || two_ch)
               s_d.st = CFM_ST_WAIT;
            if (reset_req && !off_tif.expired)
               s_d.refused = mon_en;
         end
         CFM_ST_LOCK:
         begin
            s_d.refused = reset_req && mon_en;
         end
         default:
            s_d.st = CFM_ST_LOCK;
      endcase

      if (dis_tif.expired)
         s_d.st = CFM_ST_LOCK;
      if (!mon_en && s_d.st != CFM_ST_LOCK)
         s_d.st = CFM_ST_WAIT;

      for (int i = 0; i < N_OUT; i++)
      begin
         if (mon_en && out_map[i])
            s_d.sso[i] = out_req[i] && (s_d.st == CFM_ST_RUN);
         else
            s_d.sso[i] = out_req[i];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q.st      <= CFM_ST_WAIT;
         s_q.sso     <= '0;
         s_q.refused <= 1'b0;
      end
      else
         s_q <= s_d;
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lockout_q <= 1'b0;
         armed_q   <= 1'b0;
      end
      else
      begin
         lockout_q <= (s_d.st == CFM_ST_LOCK);
         armed_q   <= (s_d.st == CFM_ST_RUN);
      end
   end

   assign sso_q           = s_q.sso;
   assign reset_refused_q = s_q.refused;

endmodule : cfm_top

`default_nettype wire

// file: rtl/cfm_window_timer.sv
`timescale 1ns/1ps
`default_nettype none

module cfm_window_timer #(
   parameter int unsigned LIMIT = 16
) (
   input  wire logic   clk,   // System clock
   input  wire logic   rst,   // Sync reset
   cfm_timer_if.timer  tif    // Condition in, expiry out
);
   localparam int unsigned CW = $clog2(LIMIT + 2);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          exp;
   } cfm_tmr_s;

   cfm_tmr_s st_q;
   cfm_tmr_s st_d;

   initial
   begin
      if (LIMIT < 2)
         $error("cfm_window_timer: LIMIT must be at least 2");
   end

   // ***************************************************
   // Counter restarts when the condition ends
   // ***************************************************
   always_comb
   begin
      st_d = st_q;
      if (!tif.cond)
      begin
         st_d.cnt = '0;
         st_d.exp = 1'b0;
      end
      else
      begin
         if (st_q.cnt != CW'(LIMIT))
            st_d.cnt = st_q.cnt + CW'(1);
         st_d.exp = (st_q.cnt >= CW'(LIMIT - 1));
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign tif.expired = st_q.exp;

endmodule : cfm_window_timer

`default_nettype wire

// file: verif/cfm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cfm_assertions
   import cfm_pkg::*;
#(
   parameter int unsigned N_OUT       = 4,
   parameter int unsigned WINDOW_CYCS = 20
) (
   input wire logic               clk,
   input wire logic               rst,
   input wire cfm_pkg::cfm_mode_e mode,
   input wire logic [N_OUT-1:0]   out_map,
   input wire logic [N_OUT-1:0]   out_req,
   input wire logic               reset_req,
   input wire logic               fb_a_closed,
   input wire logic               fb_b_closed,
   input wire logic [N_OUT-1:0]   sso_q,
   input wire logic               lockout_q,
   input wire logic               reset_refused_q,
   input wire logic               armed_q
);
   logic [31:0] dis_q;
   always_ff @(posedge clk) dis_q <= (rst || fb_a_closed == fb_b_closed) ? '0 : dis_q + 1;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_free_follow: assert property (
      !$past(rst) |=> ((sso_q ^ $past(out_req)) & ~$past(out_map)) == '0) else $error("follow");
   a_lock_off: assert property (lockout_q |=> (sso_q & out_map) == '0) else $error("lock on");
   a_lock_holds: assert property (lockout_q |=> lockout_q) else $error("lock left");
   a_arm_fb_ok: assert property ($rose(armed_q) |-> $past(reset_req) &&
      $past(fb_a_closed) && ($past(mode) != CFM_MODE_TWO || $past(fb_b_closed))) else $error("arm");
   a_refuse_open: assert property (
      mode == CFM_MODE_ONE && out_map != '0 && reset_req && !fb_a_closed && !armed_q && !lockout_q
      |=> reset_refused_q && !armed_q)
      else $error("no refuse");
   a_refuse_cause: assert property (reset_refused_q |-> $past(reset_req)) else $error("refuse");
   a_run_ignores: assert property (armed_q && !lockout_q && (out_req & out_map) != '0 &&
      (mode == CFM_MODE_ONE || fb_a_closed == fb_b_closed) |=> armed_q) else $error("disarm");
   a_mismatch_lock: assert property (
      mode == CFM_MODE_TWO && out_map != '0 && dis_q == WINDOW_CYCS + 1 |-> ##[0:4] lockout_q)
      else $error("no lock");
endmodule : cfm_assertions
bind cfm_top cfm_assertions #(.N_OUT(N_OUT), .WINDOW_CYCS(WINDOW_CYCS)) chk_u (.clk, .rst,
   .mode, .out_map, .out_req, .reset_req, .fb_a_closed, .fb_b_closed, .sso_q, .lockout_q,
   .reset_refused_q, .armed_q);
`default_nettype wire

// file: verif/cfm_contactor_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfm_contactor_model #(
   parameter int LAG = 1
) (
   input  wire logic clk,       // Clock
   input  wire logic en,        // Coil energised
   input  wire logic fault,     // Contact reads inverted
   output logic      fb_closed  // Monitor contact
);
   logic [7:0] sh_q;
   // Slow contacts: answer LAG+1 cycles late
   always_ff @(posedge clk) sh_q <= {sh_q[6:0], ~en ^ fault};
   assign fb_closed = sh_q[LAG];
endmodule : cfm_contactor_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   import cfm_pkg::*;
   localparam int unsigned W = 20;
   logic       clk = 0, rst = 1, rr = 0, fa_f = 0, fb_f = 0;
   logic [3:0] map = 4'h0, req = 4'h0, sso;
   logic       fa, fb, lk, rf, ar;
   cfm_mode_e  mode = CFM_MODE_NONE;
   int         failures = 0, checks_done = 0;
   initial forever #5 clk = ~clk;
   cfm_contactor_model #(.LAG(1)) ma_u (.clk, .en(|(sso & map)), .fault(fa_f), .fb_closed(fa));
   cfm_contactor_model #(.LAG(3)) mb_u (.clk, .en(|(sso & map)), .fault(fb_f), .fb_closed(fb));
   cfm_top #(.N_OUT(4), .WINDOW_CYCS(W)) dut_u (.clk, .rst, .mode, .out_map(map),
      .out_req(req), .reset_req(rr), .fb_a_closed(fa), .fb_b_closed(fb), .sso_q(sso),
      .lockout_q(lk), .reset_refused_q(rf), .armed_q(ar));
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task rs(input cfm_mode_e m);
      rst = 1;
      mode = m;
      cyc(2);
      rst = 0;
      cyc(4);
   endtask : rs
   task push;
      rr = 1;
      cyc(1);
      rr = 0;
   endtask : push
   task summarize;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   initial
   begin
      void'($urandom(77221));
      cyc(10);
      rst = 0;
      cyc(2);
      repeat (20)
      begin
         req = $urandom;
         map = $urandom;
         cyc(1);
         `CHK(sso, req)
      end
      map = 4'h3;
      req = 4'hF;
      fa_f = 1;
      rs(CFM_MODE_ONE);
      push;
      `CHK({rf, ar}, 2'h2)
      fa_f = 0;
      cyc(3);
      push;
      `CHK({ar, sso}, 5'h1F)
      cyc(4);
      `CHK({ar, fa}, 2'h2)
      req = 4'hC;
      cyc(1);
      fa_f = 1;
      cyc(W - 3);
      `CHK(lk, 1'b0)
      cyc(12);
      `CHK({lk, sso}, 5'h1C)
      fa_f = 0;
      fb_f = 1;
      req = 4'h3;
      rs(CFM_MODE_TWO);
      push;
      `CHK({rf, ar}, 2'h2)
      fb_f = 0;
      cyc(5);
      push;
      `CHK(ar, 1'b1)
      fa_f = 1;
      fb_f = 1;
      cyc(2 * W);
      `CHK({lk, ar}, 2'h1)
      fb_f = 0;
      cyc(W - 3);
      `CHK(lk, 1'b0)
      cyc(12);
      `CHK({lk, sso[1:0]}, 3'h4)
      summarize();
   end
   initial
   begin
      #20us;
      failures++;
      summarize();
   end
endmodule : tb
`default_nettype wire
